// [rtl/hsw_params.svh]
`ifndef HSW_PARAMS_SVH
`define HSW_PARAMS_SVH

// ============================================================
// Register offsets.
`define HSW_ADDR_W 9
`define HSW_ADDR_CTRL 9'h150
`define HSW_ADDR_CNT_HIGH 9'h151
`define HSW_ADDR_CNT_LOW 9'h152
`define HSW_ADDR_R0_HIGH 9'h153
`define HSW_ADDR_R0_LOW 9'h154
`define HSW_ADDR_R1_HIGH 9'h155
`define HSW_ADDR_R1_LOW 9'h156
`define HSW_ADDR_INT_STAT 9'h160
`define HSW_ADDR_INT_CLR 9'h161
`define HSW_ADDR_INT_EN 9'h162
`define HSW_ADDR_STATE 9'h163
`define HSW_ADDR_MANUAL 9'h164
`define HSW_ADDR_TRIP 9'h165

// ============================================================
// Reset values.
`define HSW_RST_CTRL 8'h00
`define HSW_RST_CNT_HIGH 6'h02
`define HSW_RST_CNT_LOW 8'h00
`define HSW_RST_R0_HIGH 6'h00
`define HSW_RST_R0_LOW 8'h78
`define HSW_RST_R1_HIGH 6'h00
`define HSW_RST_R1_LOW 8'h96
`define HSW_RST_MANUAL 3'h0
`define HSW_RST_TRIP 6'h00
`define HSW_RST_INT 4'h0

// ============================================================
// Field positions and widths.
`define HSW_HIGH_W 6
`define HSW_LOW_W 8
`define HSW_DIV_W 14
`define HSW_INT_W 4
`define HSW_INT_SWITCH 0
`define HSW_INT_HOLD_IN 1
`define HSW_INT_HOLD_OUT 2
`define HSW_INT_LOCK_LOST 3
`define HSW_MAN_MODE 0
`define HSW_MAN_CHOICE_LO 1
`define HSW_MAN_CHOICE_HI 2

// ============================================================
// Timing counts.
`define HSW_SETTLE_CYCLES 8'h08

`endif

// [rtl/hsw_pkg.sv]
`include "hsw_params.svh"

package hsw_pkg;

   // ============================================================
   // Switch and holdover states.
   typedef enum logic [1:0] {
      ST_LOCKED,
      ST_SWITCH,
      ST_HOLD
   } hsw_state_t;

   // ============================================================
   // Switch and holdover control register layout.
   typedef struct packed {
      logic reserved;
      logic manualInputForce;
      logic holdLeaveOnLock;
      logic lockLossSwitchEnable;
      logic externalLossSignalEnable;
      logic tuningRailDetectEnable;
      logic switchPumpFloatEnable;
      logic holdModeAllow;
   } hsw_ctrl_t;

   // ============================================================
   // Register port request.
   typedef struct packed {
      logic wr;
      logic rd;
      logic [`HSW_ADDR_W-1:0] addr;
      logic [7:0] wdata;
   } hsw_bus_t;

endpackage

// [rtl/hsw_ref_div.sv]
`timescale 1ns/1ns
`default_nettype none

module hsw_ref_div #(
   parameter int WIDTH = 14
) (
   // Clock, reset and clock enable.
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clkEn,
   // Reference edge in, divided pulse out.
   input wire logic refEdge,
   input wire logic [WIDTH-1:0] divisor,
   output logic divPulse
);

   // ============================================================
   // Parameter check.
   if (WIDTH < 1 || WIDTH > 16) begin : g_check
      $error("hsw_ref_div WIDTH out of range");
   end

   // ============================================================
   // Divider counter.
   logic [WIDTH-1:0] edgeCnt;
   wire logic divOff;
   wire logic lastEdge;

   assign divOff = (divisor == '0);
   assign lastEdge = refEdge && !divOff && (edgeCnt >= divisor - WIDTH'(1));

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         edgeCnt <= '0;
         divPulse <= 1'b0;
      end else if (clkEn) begin
         if (divOff || (refEdge && lastEdge)) begin
            edgeCnt <= '0;
         end else if (refEdge) begin
            edgeCnt <= edgeCnt + WIDTH'(1);
         end
         divPulse <= lastEdge;
      end
   end

   // ============================================================
   // Checks.
   property p_div_zero_silent;
      @(posedge mclk) disable iff (!rst_n)
      clkEn && divOff |=> !divPulse;
   endproperty
   a_div_zero_silent: assert property (p_div_zero_silent) else $error("divider pulsed with zero divisor");

   property p_div_by_one;
      @(posedge mclk) disable iff (!rst_n)
      clkEn && refEdge && divisor == WIDTH'(1) |=> divPulse;
   endproperty
   a_div_by_one: assert property (p_div_by_one) else $error("divide by one missed an edge");

endmodule

`default_nettype wire

// [rtl/hsw_top.sv]
// Local design decision: strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "hsw_params.svh"

module hsw_top (
   // Clock, reset and clock enable.
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clkEn,
   // Register port.
   input wire hsw_pkg::hsw_bus_t busReq,
   output logic [7:0] regRdData,
   // Loss-of-signal sources.
   input wire logic [2:0] lossDetActive,
   input wire logic inputChoicePin0,
   input wire logic inputChoicePin1,
   input wire logic statusPinOne,
   // First loop status.
   input wire logic lockIndicator,
   input wire logic [6:0] tuneLevel,
   // Reference inputs and divided outputs.
   input wire logic [1:0] refEdge,
   output logic [1:0] refDivPulse,
   // Loop control outputs.
   output logic [1:0] selInput,
   output logic holdActive,
   output logic pumpFloat,
   output logic ddlyEnable,
   output logic irq
);

   // ============================================================
   // Register storage.
   hsw_pkg::hsw_ctrl_t ctrl;
   logic [`HSW_HIGH_W-1:0] cntHigh;
   logic [`HSW_LOW_W-1:0] cntLow;
   logic [`HSW_HIGH_W-1:0] r0High;
   logic [`HSW_LOW_W-1:0] r0Low;
   logic [`HSW_HIGH_W-1:0] r1High;
   logic [`HSW_LOW_W-1:0] r1Low;
   logic [2:0] manual;
   logic [5:0] tripLow;
   logic [`HSW_INT_W-1:0] intStat;
   logic [`HSW_INT_W-1:0] intEn;

   // ============================================================
   // Control state.
   hsw_pkg::hsw_state_t state;
   hsw_pkg::hsw_state_t next_state;
   logic [`HSW_DIV_W-1:0] exitCnt;
   logic [7:0] settleCnt;
   logic lockPrev;

   // ============================================================
   // Address decode.
   wire logic wrCtrl;
   wire logic wrCntHigh;
   wire logic wrCntLow;
   wire logic wrR0High;
   wire logic wrR0Low;
   wire logic wrR1High;
   wire logic wrR1Low;
   wire logic wrIntClr;
   wire logic wrIntEn;
   wire logic wrManual;
   wire logic wrTrip;

   assign wrCtrl = busReq.wr && busReq.addr == `HSW_ADDR_CTRL;
   assign wrCntHigh = busReq.wr && busReq.addr == `HSW_ADDR_CNT_HIGH;
   assign wrCntLow = busReq.wr && busReq.addr == `HSW_ADDR_CNT_LOW;
   assign wrR0High = busReq.wr && busReq.addr == `HSW_ADDR_R0_HIGH;
   assign wrR0Low = busReq.wr && busReq.addr == `HSW_ADDR_R0_LOW;
   assign wrR1High = busReq.wr && busReq.addr == `HSW_ADDR_R1_HIGH;
   assign wrR1Low = busReq.wr && busReq.addr == `HSW_ADDR_R1_LOW;
   assign wrIntClr = busReq.wr && busReq.addr == `HSW_ADDR_INT_CLR;
   assign wrIntEn = busReq.wr && busReq.addr == `HSW_ADDR_INT_EN;
   assign wrManual = busReq.wr && busReq.addr == `HSW_ADDR_MANUAL;
   assign wrTrip = busReq.wr && busReq.addr == `HSW_ADDR_TRIP;

   // ============================================================
   // Read selection.
   wire logic [2:0] losActive;
   wire logic [7:0] stateView;
   wire logic [7:0] rdValue;

   assign stateView = {1'b0, losActive, pumpFloat, holdActive, selInput};
   assign rdValue =
      (busReq.addr == `HSW_ADDR_CTRL) ? {1'b0, ctrl[6:0]} :
      (busReq.addr == `HSW_ADDR_CNT_HIGH) ? {2'h0, cntHigh} :
      (busReq.addr == `HSW_ADDR_CNT_LOW) ? cntLow :
      (busReq.addr == `HSW_ADDR_R0_HIGH) ? {2'h0, r0High} :
      (busReq.addr == `HSW_ADDR_R0_LOW) ? r0Low :
      (busReq.addr == `HSW_ADDR_R1_HIGH) ? {2'h0, r1High} :
      (busReq.addr == `HSW_ADDR_R1_LOW) ? r1Low :
      (busReq.addr == `HSW_ADDR_INT_STAT) ? {4'h0, intStat} :
      (busReq.addr == `HSW_ADDR_INT_EN) ? {4'h0, intEn} :
      (busReq.addr == `HSW_ADDR_STATE) ? stateView :
      (busReq.addr == `HSW_ADDR_MANUAL) ? {5'h00, manual} :
      (busReq.addr == `HSW_ADDR_TRIP) ? {2'h0, tripLow} :
      8'h00;

   // ============================================================
   // Input validity, forcing and switch triggers.
   wire logic forced;
   wire logic [1:0] forcedSel;
   wire logic lockFall;
   wire logic lockEvent;
   wire logic tripHit;
   wire logic switchEvent;

   assign losActive = ctrl.externalLossSignalEnable ?
      ~{statusPinOne, inputChoicePin1, inputChoicePin0} : lossDetActive;
   assign forced = manual[`HSW_MAN_MODE] && ctrl.manualInputForce;
   assign forcedSel = (manual[`HSW_MAN_CHOICE_HI:`HSW_MAN_CHOICE_LO] == 2'h3) ?
      2'h0 : manual[`HSW_MAN_CHOICE_HI:`HSW_MAN_CHOICE_LO];
   assign lockFall = lockPrev && !lockIndicator;
   assign lockEvent = ctrl.lockLossSwitchEnable && lockFall;
   assign tripHit = ctrl.tuningRailDetectEnable &&
      (tuneLevel <= ({1'b0, tripLow} + 7'h01));
   assign switchEvent = (lockEvent || tripHit) && state == hsw_pkg::ST_LOCKED;

   // ============================================================
   // Automatic input choice.
   wire logic [1:0] selP1;
   wire logic [1:0] selP2;
   wire logic [1:0] autoSel;
   wire logic [1:0] next_sel;

   assign selP1 = (selInput == 2'h2) ? 2'h0 : selInput + 2'h1;
   assign selP2 = (selP1 == 2'h2) ? 2'h0 : selP1 + 2'h1;
   assign autoSel = losActive[selP1] ? selP1 : (losActive[selP2] ? selP2 : selP1);
   assign next_sel = forced ? forcedSel : (switchEvent ? autoSel : selInput);

   // ============================================================
   // Holdover exit criterion.
   wire logic [`HSW_DIV_W-1:0] holdTarget;
   wire logic exitMet;
   wire logic exitDone;

   assign holdTarget = {cntHigh, cntLow};
   assign exitMet = ctrl.holdLeaveOnLock ? lockIndicator : losActive[selInput];
   assign exitDone = exitCnt >= holdTarget;

   // ============================================================
   // Interrupt status.
   wire logic [`HSW_INT_W-1:0] intEvent;
   wire logic [`HSW_INT_W-1:0] intClr;
   wire logic [`HSW_INT_W-1:0] next_intStat;

   assign intEvent = {lockFall,
                      state == hsw_pkg::ST_HOLD && next_state == hsw_pkg::ST_LOCKED,
                      switchEvent && ctrl.holdModeAllow,
                      switchEvent};
   assign intClr = wrIntClr ? busReq.wdata[`HSW_INT_W-1:0] : `HSW_RST_INT;
   assign next_intStat = (intStat & ~intClr) | intEvent;

   // ============================================================
   // State sequencing.
   always_comb begin
      next_state = state;
      case (state)
         hsw_pkg::ST_LOCKED: begin
            if (switchEvent) begin
               next_state = ctrl.holdModeAllow ? hsw_pkg::ST_HOLD : hsw_pkg::ST_SWITCH;
            end
         end
         hsw_pkg::ST_SWITCH: begin
            if (settleCnt == 8'h00) begin
               next_state = hsw_pkg::ST_LOCKED;
            end
         end
         hsw_pkg::ST_HOLD: begin
            if (!ctrl.holdModeAllow || exitDone) begin
               next_state = hsw_pkg::ST_LOCKED;
            end
         end
         default: begin
            next_state = hsw_pkg::ST_LOCKED;
         end
      endcase
   end

   // ============================================================
   // Register writes.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ctrl <= `HSW_RST_CTRL;
         cntHigh <= `HSW_RST_CNT_HIGH;
         cntLow <= `HSW_RST_CNT_LOW;
         r0High <= `HSW_RST_R0_HIGH;
         r0Low <= `HSW_RST_R0_LOW;
         r1High <= `HSW_RST_R1_HIGH;
         r1Low <= `HSW_RST_R1_LOW;
         manual <= `HSW_RST_MANUAL;
         tripLow <= `HSW_RST_TRIP;
         intEn <= `HSW_RST_INT;
      end else if (clkEn) begin
         if (wrCtrl) ctrl <= {1'b0, busReq.wdata[6:0]};
         if (wrCntHigh) cntHigh <= busReq.wdata[`HSW_HIGH_W-1:0];
         if (wrCntLow) cntLow <= busReq.wdata;
         if (wrR0High) r0High <= busReq.wdata[`HSW_HIGH_W-1:0];
         if (wrR0Low) r0Low <= busReq.wdata;
         if (wrR1High) r1High <= busReq.wdata[`HSW_HIGH_W-1:0];
         if (wrR1Low) r1Low <= busReq.wdata;
         if (wrManual) manual <= busReq.wdata[2:0];
         if (wrTrip) tripLow <= busReq.wdata[5:0];
         if (wrIntEn) intEn <= busReq.wdata[`HSW_INT_W-1:0];
      end
   end

   // ============================================================
   // Read data and interrupt.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         regRdData <= 8'h00;
         intStat <= `HSW_RST_INT;
         irq <= 1'b0;
      end else if (clkEn) begin
         regRdData <= busReq.rd ? rdValue : 8'h00;
         intStat <= next_intStat;
         irq <= |(next_intStat & intEn);
      end
   end

   // ============================================================
   // Switch, holdover and exit counting.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state <= hsw_pkg::ST_LOCKED;
         exitCnt <= '0;
         settleCnt <= 8'h00;
         lockPrev <= 1'b0;
      end else if (clkEn) begin
         state <= next_state;
         lockPrev <= lockIndicator;
         if (next_state == hsw_pkg::ST_SWITCH && state != hsw_pkg::ST_SWITCH) begin
            settleCnt <= `HSW_SETTLE_CYCLES;
         end else if (settleCnt != 8'h00) begin
            settleCnt <= settleCnt - 8'h01;
         end
         if (state != hsw_pkg::ST_HOLD || !exitMet) begin
            exitCnt <= '0;
         end else if (!exitDone) begin
            exitCnt <= exitCnt + 14'h0001;
         end
      end
   end

   // ============================================================
   // Loop control outputs.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         selInput <= 2'h0;
         holdActive <= 1'b0;
         pumpFloat <= 1'b0;
         ddlyEnable <= 1'b1;
      end else if (clkEn) begin
         selInput <= next_sel;
         holdActive <= next_state == hsw_pkg::ST_HOLD;
         pumpFloat <= ctrl.switchPumpFloatEnable && next_state != hsw_pkg::ST_LOCKED;
         ddlyEnable <= !forced;
      end
   end

   // ============================================================
   // Reference dividers.
   wire logic [`HSW_DIV_W-1:0] divisor [2];

   assign divisor[0] = {r0High, r0Low};
   assign divisor[1] = {r1High, r1Low};

   for (genvar gi = 0; gi < 2; gi++) begin : g_div
      hsw_ref_div #(
         .WIDTH(`HSW_DIV_W)
      ) u_div (
         .mclk(mclk),
         .rst_n(rst_n),
         .clkEn(clkEn),
         .refEdge(refEdge[gi]),
         .divisor(divisor[gi]),
         .divPulse(refDivPulse[gi])
      );
   end

   // ============================================================
   // Checks.
   property p_force_sel;
      @(posedge mclk) disable iff (!rst_n)
      clkEn && forced |=> selInput == $past(forcedSel);
   endproperty
   a_force_sel: assert property (p_force_sel) else $error("forced input not selected");

   property p_force_ddly;
      @(posedge mclk) disable iff (!rst_n)
      clkEn && forced |=> !ddlyEnable;
   endproperty
   a_force_ddly: assert property (p_force_ddly) else $error("delay adjust left on while forced");

   property p_exit_los;
      @(posedge mclk) disable iff (!rst_n)
      clkEn && state == hsw_pkg::ST_HOLD && !ctrl.holdLeaveOnLock && !losActive[selInput] |=> exitCnt == '0;
   endproperty
   a_exit_los: assert property (p_exit_los) else $error("exit count ran without active input");

   property p_exit_lock;
      @(posedge mclk) disable iff (!rst_n)
      clkEn && state == hsw_pkg::ST_HOLD && ctrl.holdLeaveOnLock && !lockIndicator |=> exitCnt == '0;
   endproperty
   a_exit_lock: assert property (p_exit_lock) else $error("exit count ran without lock");

   property p_lock_loss;
      @(posedge mclk) disable iff (!rst_n)
      clkEn && state == hsw_pkg::ST_LOCKED && ctrl.lockLossSwitchEnable && lockPrev && !lockIndicator
      |=> intStat[`HSW_INT_SWITCH] && state != hsw_pkg::ST_LOCKED;
   endproperty
   a_lock_loss: assert property (p_lock_loss) else $error("lock loss raised no switch");

   property p_ext_pin;
      @(posedge mclk) disable iff (!rst_n)
      clkEn && state == hsw_pkg::ST_HOLD && !ctrl.holdLeaveOnLock && ctrl.externalLossSignalEnable
      && selInput == 2'h0 && inputChoicePin0 |=> exitCnt == '0;
   endproperty
   a_ext_pin: assert property (p_ext_pin) else $error("external loss pin ignored");

   property p_trip;
      @(posedge mclk) disable iff (!rst_n)
      clkEn && state == hsw_pkg::ST_LOCKED && ctrl.tuningRailDetectEnable
      && tuneLevel <= ({1'b0, tripLow} + 7'h01) |=> state != hsw_pkg::ST_LOCKED;
   endproperty
   a_trip: assert property (p_trip) else $error("tuning trip raised no switch");

   property p_pump;
      @(posedge mclk) disable iff (!rst_n)
      clkEn |=> pumpFloat == ($past(ctrl.switchPumpFloatEnable) && state != hsw_pkg::ST_LOCKED);
   endproperty
   a_pump: assert property (p_pump) else $error("pump float wrong during switch");

   property p_hold_off;
      @(posedge mclk) disable iff (!rst_n)
      clkEn && !ctrl.holdModeAllow |=> !holdActive;
   endproperty
   a_hold_off: assert property (p_hold_off) else $error("holdover active while disallowed");

   property p_exit_done;
      @(posedge mclk) disable iff (!rst_n)
      clkEn && state == hsw_pkg::ST_HOLD && exitCnt >= holdTarget |=> state == hsw_pkg::ST_LOCKED && !holdActive;
   endproperty
   a_exit_done: assert property (p_exit_done) else $error("holdover kept after count reached");

   property p_count_step;
      @(posedge mclk) disable iff (!rst_n)
      clkEn && state == hsw_pkg::ST_HOLD && exitMet && exitCnt < holdTarget |=> exitCnt == $past(exitCnt) + 14'h0001;
   endproperty
   a_count_step: assert property (p_count_step) else $error("exit count did not step");

endmodule

`default_nettype wire

// [rtl/dummy_unused_never.sv]
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// [test/hsw_ref_src.sv]
`timescale 1ns/1ns
`default_nettype none

// ============================================================
// Reference sources and loss pins on the far side.
module hsw_ref_src (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst_n,
   // Source control.
   input wire logic [2:0] alive,
   input wire logic [2:0] pinAlive,
   input wire logic [3:0] gap,
   // Reference edges and loss indications.
   output logic [1:0] refEdge,
   output logic [2:0] lossDetActive,
   output logic inputChoicePin0,
   output logic inputChoicePin1,
   output logic statusPinOne
);
   logic [3:0] cnt;

   always_ff @(posedge mclk) begin
      if (!rst_n || cnt >= gap) begin
         cnt <= 4'h0;
      end else begin
         cnt <= cnt + 4'h1;
      end
   end

   // Edges come as single-cycle pulses spaced by the gap.
   assign refEdge = (cnt == 4'h0 && rst_n) ? alive[1:0] : 2'h0;
   assign lossDetActive = alive;
   // The pins are inputs of the device and read high while the signal is lost.
   assign inputChoicePin0 = ~pinAlive[0];
   assign inputChoicePin1 = ~pinAlive[1];
   assign statusPinOne = ~pinAlive[2];
endmodule
`default_nettype wire

// [test/holdover_switch_and_ref_dividers_bench.sv]
`timescale 1ns/1ns
`default_nettype none
`include "hsw_params.svh"

module holdover_switch_and_ref_dividers_bench;
   logic mclk, rst_n, clkEn, lockIndicator, pin0, pin1, pinS;
   hsw_pkg::hsw_bus_t busReq;
   logic [7:0] regRdData, rv;
   logic [2:0] alive, pinAlive, lossDet;
   logic [3:0] gap;
   logic [6:0] tuneLevel;
   logic [1:0] refEdge, refDivPulse, selInput;
   logic holdActive, pumpFloat, ddlyEnable, irq;
   logic [15:0] len, t, n;
   logic [15:0] eCnt [2] = '{16'h0, 16'h0};
   logic [15:0] lastIv [2] = '{16'h0, 16'h0};
   logic [15:0] pulses [2] = '{16'h0, 16'h0};
   logic [7:0] rstTab [7] = '{8'h00, 8'h02, 8'h00, 8'h00, 8'h78, 8'h00, 8'h96};
   int error_cnt = 0;
   int comparisons = 0;

   hsw_top i_hsw_top (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn), .busReq(busReq), .regRdData(regRdData),
      .lossDetActive(lossDet), .inputChoicePin0(pin0), .inputChoicePin1(pin1), .statusPinOne(pinS),
      .lockIndicator(lockIndicator), .tuneLevel(tuneLevel), .refEdge(refEdge), .refDivPulse(refDivPulse),
      .selInput(selInput), .holdActive(holdActive), .pumpFloat(pumpFloat), .ddlyEnable(ddlyEnable), .irq(irq));
   hsw_ref_src i_hsw_ref_src (.mclk(mclk), .rst_n(rst_n), .alive(alive), .pinAlive(pinAlive), .gap(gap),
      .refEdge(refEdge), .lossDetActive(lossDet), .inputChoicePin0(pin0), .inputChoicePin1(pin1),
      .statusPinOne(pinS));

   // ============================================================
   // Clock, divider monitor and watchdog.
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      for (int i = 0; i < 2; i++) begin
         if (refDivPulse[i] === 1'b1) begin
            lastIv[i] = eCnt[i];
            pulses[i] = pulses[i] + 16'h1;
            eCnt[i] = 16'(refEdge[i]);
         end else begin
            eCnt[i] = eCnt[i] + 16'(refEdge[i]);
         end
      end
   end

   initial begin
      #(8 * 40000);
      error_cnt++;
      test_done();
   end

   // ============================================================
   // Tasks.
   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d.", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      @(posedge mclk);
      busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge mclk);
      busReq <= '0;
   endtask

   task automatic rchk(input logic [8:0] a, input logic [7:0] exp);
      @(posedge mclk);
      busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge mclk);
      busReq <= '0;
      #1;
      rv = regRdData;
      chk(16'(rv), 16'(exp));
   endtask

   task automatic cyc(input int c);
      repeat (c) @(posedge mclk);
      #1;
   endtask

   task automatic trip();
      @(posedge mclk);
      tuneLevel <= 7'(n + 16'h1);
      @(posedge mclk);
      tuneLevel <= 7'h40;
   endtask

   task automatic highLen(input logic pick);
      int k;
      len = 16'h0;
      k = 0;
      #1;
      while ((pick ? pumpFloat : holdActive) !== 1'b1 && k < 50) begin
         cyc(1);
         k++;
      end
      while ((pick ? pumpFloat : holdActive) === 1'b1 && len < 16'h4e20) begin
         cyc(1);
         len++;
      end
   endtask

   // ============================================================
   // Main sequence.
   initial begin
      rst_n = 1'b0;
      clkEn = 1'b1;
      busReq = '0;
      alive = 3'h7;
      pinAlive = 3'h7;
      gap = 4'h2;
      lockIndicator = 1'b1;
      tuneLevel = 7'h40;
      void'($urandom(21));
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      for (int i = 0; i < 7; i++) rchk(9'h150 + 9'(i), rstTab[i]);
      rchk(9'h1ff, 8'h00);
      for (int i = 1; i < 7; i++) begin
         n = 16'($urandom);
         wr(9'h150 + 9'(i), n[7:0]);
         rchk(9'h150 + 9'(i), (i % 2 == 1) ? n[7:0] & 8'h3f : n[7:0]);
      end
      n = 16'h1 + 16'($urandom % 6);
      wr(`HSW_ADDR_R0_HIGH, 8'h00);
      wr(`HSW_ADDR_R0_LOW, n[7:0]);
      wr(`HSW_ADDR_R1_HIGH, 8'h00);
      wr(`HSW_ADDR_R1_LOW, 8'h01);
      cyc(200);
      chk(lastIv[0], n);
      chk(lastIv[1], 16'h1);
      wr(`HSW_ADDR_R1_LOW, 8'h00);
      cyc(2);
      len = pulses[1];
      cyc(60);
      chk(pulses[1], len);
      t = 16'h1 + 16'($urandom % 20);
      wr(`HSW_ADDR_CNT_HIGH, 8'h00);
      wr(`HSW_ADDR_CNT_LOW, t[7:0]);
      wr(`HSW_ADDR_INT_EN, 8'h0f);
      wr(`HSW_ADDR_CTRL, 8'h11);
      @(posedge mclk);
      lockIndicator <= 1'b0;
      highLen(1'b0);
      chk(len, t + 16'h1);
      rchk(`HSW_ADDR_INT_STAT, 8'h0f);
      chk(16'(irq), 16'h1);
      wr(`HSW_ADDR_INT_CLR, 8'h0f);
      cyc(2);
      chk(16'(irq), 16'h0);
      rchk(`HSW_ADDR_INT_STAT, 8'h00);
      lockIndicator <= 1'b1;
      wr(`HSW_ADDR_CTRL, 8'h01);
      @(posedge mclk);
      lockIndicator <= 1'b0;
      cyc(5);
      chk(16'(holdActive), 16'h0);
      rchk(`HSW_ADDR_INT_STAT, 8'h08);
      t = 16'h3 + 16'($urandom % 10);
      wr(`HSW_ADDR_CNT_LOW, t[7:0]);
      wr(`HSW_ADDR_INT_CLR, 8'h0f);
      lockIndicator <= 1'b1;
      wr(`HSW_ADDR_CTRL, 8'h31);
      @(posedge mclk);
      lockIndicator <= 1'b0;
      repeat (3) begin
         cyc(2);
         @(posedge mclk);
         lockIndicator <= 1'b1;
         @(posedge mclk);
         lockIndicator <= 1'b0;
      end
      cyc(2);
      chk(16'(holdActive), 16'h1);
      @(posedge mclk);
      lockIndicator <= 1'b1;
      highLen(1'b0);
      chk(len, t + 16'h1);
      wr(`HSW_ADDR_INT_CLR, 8'h0f);
      wr(`HSW_ADDR_INT_EN, 8'h00);
      n = 16'($urandom % 60);
      wr(`HSW_ADDR_TRIP, n[7:0]);
      wr(`HSW_ADDR_CTRL, 8'h06);
      tuneLevel <= 7'(n + 16'h2);
      alive <= 3'h2;
      cyc(5);
      chk(16'(pumpFloat), 16'h0);
      trip();
      highLen(1'b1);
      chk(len, 16'(`HSW_SETTLE_CYCLES) + 16'h1);
      chk(16'(holdActive), 16'h0);
      chk(16'(selInput), 16'h1);
      rchk(`HSW_ADDR_INT_STAT, 8'h01);
      chk(16'(irq), 16'h0);
      alive <= 3'h7;
      pinAlive <= 3'($urandom);
      wr(`HSW_ADDR_CTRL, 8'h08);
      rchk(`HSW_ADDR_STATE, {1'b0, pinAlive, 4'h1});
      chk(16'(rv[6:4]), 16'(pinAlive));
      wr(`HSW_ADDR_CTRL, 8'h00);
      rchk(`HSW_ADDR_STATE, 8'h71);
      chk(16'(rv[6:4]), 16'h7);
      wr(`HSW_ADDR_MANUAL, 8'h01);
      pinAlive <= 3'h6;
      wr(`HSW_ADDR_CTRL, 8'h59);
      @(posedge mclk);
      lockIndicator <= 1'b0;
      cyc(20);
      chk(16'(holdActive), 16'h1);
      chk(16'(selInput), 16'h0);
      pinAlive <= 3'h7;
      cyc(20);
      chk(16'(holdActive), 16'h0);
      lockIndicator <= 1'b1;
      for (int c = 0; c < 3; c++) begin
         wr(`HSW_ADDR_MANUAL, {5'h00, 2'(c), 1'b1});
         wr(`HSW_ADDR_CTRL, 8'h44);
         trip();
         cyc(3);
         chk(16'(pumpFloat), 16'h0);
         cyc(12);
         chk(16'(selInput), 16'(c));
         chk(16'(ddlyEnable), 16'h0);
      end
      wr(`HSW_ADDR_CTRL, 8'h00);
      cyc(2);
      chk(16'(ddlyEnable), 16'h1);
      test_done();
   end
endmodule
`default_nettype wire
